// ---- ssihr_regs.svh ----
// register offsets, field positions, reset values and sizes for the serial slave irq/host register group
// assumes a byte-addressed AXI4-Lite port with 8 address bits and 32-bit data
`ifndef SSIHR_REGS_SVH
`define SSIHR_REGS_SVH

`define SSIHR_ADDR_W 8
`define SSIHR_OFF_DATA 8'h00
`define SSIHR_OFF_CONFIG 8'h04
`define SSIHR_OFF_MASK 8'h08
`define SSIHR_OFF_RAW 8'h0C
`define SSIHR_OFF_MASKED 8'h10
`define SSIHR_OFF_CLEAR 8'h14
`define SSIHR_OFF_DMA 8'h18
`define SSIHR_OFF_TEST 8'h1C
`define SSIHR_OFF_HSTAT 8'h20
`define SSIHR_OFF_HOST_CONTROL_IN 8'h24
`define SSIHR_OFF_I2CDBG 8'h28
`define SSIHR_OFF_SPIDBG 8'h2C

`define SSIHR_BIT_OVERRUN 3
`define SSIHR_BIT_BREAK 2
`define SSIHR_BIT_TRANSMIT 1
`define SSIHR_BIT_RECEIVE 0
`define SSIHR_BIT_CTRL_EN 6
`define SSIHR_BIT_STAT_EN 5

`define SSIHR_RST_IRQ 4'h0
`define SSIHR_RST_I2CDBG 26'h000000E
`define SSIHR_RST_SPIDBG 24'h400000
`define SSIHR_IDLE_BYTE 8'hFF

`define SSIHR_FIFO_DEPTH 5'h08
`define SSIHR_PTR_W 4

`define SSIHR_RESP_OKAY 2'h0
`define SSIHR_RESP_SLVERR 2'h2

`endif

// ---- ssihr_pkg.sv ----
// types shared by the serial slave irq/host register group
// assumes nothing beyond the offsets header
package ssihr_pkg;
  typedef logic [3:0] ssihr_irq_type;
  typedef logic [7:0] ssihr_byte_type;
  typedef logic [3:0] ssihr_ptr_type;
  typedef logic [7:0] ssihr_addr_type;
endpackage

// ---- ssihr_top.sv ----
// interrupt, test and host-exchange registers of a combined serial slave, with a serial host link
// assumes an AXI4-Lite master on aclk and an external host driving link_sck/link_sel_n/link_mosi asynchronously
`timescale 1ns/10ps
`include "ssihr_regs.svh"
module ssihr_top
  import ssihr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_sck,
  input wire logic link_sel_n,
  input wire logic link_mosi,
  output logic link_miso,
  output logic link_miso_oe,
  output logic irq
);

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic known_addr(input ssihr_addr_type a);
    return a == `SSIHR_OFF_DATA || a == `SSIHR_OFF_CONFIG || a == `SSIHR_OFF_MASK || a == `SSIHR_OFF_RAW ||
           a == `SSIHR_OFF_MASKED || a == `SSIHR_OFF_CLEAR || a == `SSIHR_OFF_DMA || a == `SSIHR_OFF_TEST ||
           a == `SSIHR_OFF_HSTAT || a == `SSIHR_OFF_HOST_CONTROL_IN || a == `SSIHR_OFF_I2CDBG || a == `SSIHR_OFF_SPIDBG;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic aw_have_q, w_have_q, ar_have_q;
  ssihr_addr_type awaddr_q, araddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  ssihr_irq_type mask_q, raw_q, raw_d;
  logic ctrl_en_q, stat_en_q;
  logic [3:0] host_stat_q;
  ssihr_byte_type host_ctrl_q;
  logic [25:0] i2c_dbg_q;
  logic [23:0] spi_dbg_q;
  ssihr_byte_type rx_mem [0:7];
  ssihr_byte_type tx_mem [0:7];
  ssihr_ptr_type rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
  logic sck_s1_q, sck_s2_q, sck_s3_q, sel_s1_q, sel_s2_q, sel_s3_q, mosi_s1_q, mosi_s2_q;
  logic [2:0] bit_cnt_q;
  logic first_q;
  ssihr_byte_type rx_shift_q, tx_shift_q;

  // ----------------------------------------------------------------
  // fifo status and link events
  // ----------------------------------------------------------------
  ssihr_ptr_type rx_cnt, tx_cnt;
  logic rx_empty, rx_full, tx_empty, tx_full;
  assign rx_cnt = rx_wp_q - rx_rp_q;
  assign tx_cnt = tx_wp_q - tx_rp_q;
  assign rx_empty = rx_cnt == 4'h0;
  assign tx_empty = tx_cnt == 4'h0;
  assign rx_full = {1'b0, rx_cnt} == `SSIHR_FIFO_DEPTH;
  assign tx_full = {1'b0, tx_cnt} == `SSIHR_FIFO_DEPTH;

  logic sel_fall, sel_rise, sck_rise, sck_fall, byte_done, cap_ctrl;
  logic link_push, link_pop, load_next, send_stat;
  ssihr_byte_type rx_byte, stat_byte, tx_next;
  ssihr_irq_type events;
  assign sel_fall = !sel_s2_q && sel_s3_q;
  assign sel_rise = sel_s2_q && !sel_s3_q;
  assign sck_rise = sck_s2_q && !sck_s3_q && !sel_s2_q;
  assign sck_fall = !sck_s2_q && sck_s3_q && !sel_s2_q;
  assign byte_done = sck_rise && bit_cnt_q == 3'h7;
  assign rx_byte = {rx_shift_q[6:0], mosi_s2_q};
  assign cap_ctrl = byte_done && first_q && ctrl_en_q;
  assign link_push = byte_done && !cap_ctrl && !rx_full;
  assign stat_byte = {host_stat_q, tx_full, tx_empty, rx_full, rx_empty};
  assign send_stat = sel_fall && stat_en_q;
  assign load_next = sel_fall || byte_done;
  assign link_pop = load_next && !send_stat && !tx_empty;
  assign tx_next = send_stat ? stat_byte : (tx_empty ? `SSIHR_IDLE_BYTE : tx_mem[tx_rp_q[2:0]]);
  // a frame that ends mid-character is reported as a break
  assign events[`SSIHR_BIT_OVERRUN] = byte_done && !cap_ctrl && rx_full;
  assign events[`SSIHR_BIT_BREAK] = sel_rise && bit_cnt_q != 3'h0;
  assign events[`SSIHR_BIT_TRANSMIT] = link_pop;
  assign events[`SSIHR_BIT_RECEIVE] = link_push;

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  logic aw_hs, w_hs, ar_hs, wr_go, rd_go, wr_on, bvalid_next, rvalid_next;
  // the fifo ports are single; software yields a cycle when the link uses the same port
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid && !(link_push && awaddr_q == `SSIHR_OFF_TEST);
  assign rd_go = ar_have_q && !s_axi_rvalid && !(link_pop && araddr_q == `SSIHR_OFF_TEST);
  assign wr_on = wr_go && wstrb_q[0];
  assign bvalid_next = wr_go || (s_axi_bvalid && !s_axi_bready);
  assign rvalid_next = rd_go || (s_axi_rvalid && !s_axi_rready);

  logic sw_rx_push, sw_rx_pop, sw_tx_push, sw_tx_pop;
  ssihr_irq_type clr;
  assign sw_rx_push = wr_on && awaddr_q == `SSIHR_OFF_TEST && !rx_full;
  assign sw_tx_pop = rd_go && araddr_q == `SSIHR_OFF_TEST && !tx_empty;
  assign sw_rx_pop = rd_go && araddr_q == `SSIHR_OFF_DATA && !rx_empty;
  assign sw_tx_push = wr_on && awaddr_q == `SSIHR_OFF_DATA && !tx_full;
  assign clr = (wr_on && awaddr_q == `SSIHR_OFF_CLEAR) ? wdata_q[3:0] : 4'h0;
  assign raw_d = (raw_q & ~clr) | events;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSIHR_RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
        awaddr_q <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_have_q <= aw_hs || (aw_have_q && !wr_go);
      w_have_q <= w_hs || (w_have_q && !wr_go);
      s_axi_awready <= !(aw_hs || (aw_have_q && !wr_go)) && !bvalid_next;
      s_axi_wready <= !(w_hs || (w_have_q && !wr_go)) && !bvalid_next;
      s_axi_bvalid <= bvalid_next;
      if (wr_go)
        s_axi_bresp <= known_addr(awaddr_q) ? `SSIHR_RESP_OKAY : `SSIHR_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ar_have_q <= 1'b0;
      araddr_q <= 8'h00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SSIHR_RESP_OKAY;
    end
    else
    begin
      if (ar_hs)
        araddr_q <= s_axi_araddr;
      ar_have_q <= ar_hs || (ar_have_q && !rd_go);
      s_axi_arready <= !(ar_hs || (ar_have_q && !rd_go)) && !rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (rd_go)
      begin
        s_axi_rresp <= known_addr(araddr_q) ? `SSIHR_RESP_OKAY : `SSIHR_RESP_SLVERR;
        // reserved bits and the unused dma register read as zero
        unique case (araddr_q)
          `SSIHR_OFF_DATA: s_axi_rdata <= {24'h0, rx_empty ? 8'h00 : rx_mem[rx_rp_q[2:0]]};
          `SSIHR_OFF_CONFIG: s_axi_rdata <= {25'h0, ctrl_en_q, stat_en_q, 5'h00};
          `SSIHR_OFF_MASK: s_axi_rdata <= {28'h0, mask_q};
          `SSIHR_OFF_RAW: s_axi_rdata <= {28'h0, raw_q};
          `SSIHR_OFF_MASKED: s_axi_rdata <= {28'h0, raw_q & mask_q};
          `SSIHR_OFF_TEST: s_axi_rdata <= {24'h0, tx_empty ? 8'h00 : tx_mem[tx_rp_q[2:0]]};
          `SSIHR_OFF_HSTAT: s_axi_rdata <= {28'h0, host_stat_q};
          `SSIHR_OFF_HOST_CONTROL_IN: s_axi_rdata <= {24'h0, host_ctrl_q};
          `SSIHR_OFF_I2CDBG: s_axi_rdata <= {6'h0, i2c_dbg_q};
          `SSIHR_OFF_SPIDBG: s_axi_rdata <= {8'h0, spi_dbg_q};
          default: s_axi_rdata <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [31:0] wmerged;
  always_comb
  begin
    unique case (awaddr_q)
      `SSIHR_OFF_CONFIG: wmerged = apply_strb({25'h0, ctrl_en_q, stat_en_q, 5'h00}, wdata_q, wstrb_q);
      `SSIHR_OFF_HOST_CONTROL_IN: wmerged = apply_strb({24'h0, host_ctrl_q}, wdata_q, wstrb_q);
      `SSIHR_OFF_I2CDBG: wmerged = apply_strb({6'h0, i2c_dbg_q}, wdata_q, wstrb_q);
      `SSIHR_OFF_SPIDBG: wmerged = apply_strb({8'h0, spi_dbg_q}, wdata_q, wstrb_q);
      default: wmerged = apply_strb(32'h0, wdata_q, wstrb_q);
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask_q <= `SSIHR_RST_IRQ;
      ctrl_en_q <= 1'b0;
      stat_en_q <= 1'b0;
      host_stat_q <= 4'h0;
      i2c_dbg_q <= `SSIHR_RST_I2CDBG;
      spi_dbg_q <= `SSIHR_RST_SPIDBG;
    end
    else if (wr_go)
    begin
      if (awaddr_q == `SSIHR_OFF_MASK && wstrb_q[0])
        mask_q <= wdata_q[3:0];
      if (awaddr_q == `SSIHR_OFF_CONFIG)
      begin
        ctrl_en_q <= wmerged[`SSIHR_BIT_CTRL_EN];
        stat_en_q <= wmerged[`SSIHR_BIT_STAT_EN];
      end
      if (awaddr_q == `SSIHR_OFF_HSTAT && wstrb_q[0])
        host_stat_q <= wdata_q[3:0];
      if (awaddr_q == `SSIHR_OFF_I2CDBG)
        i2c_dbg_q <= wmerged[25:0];
      if (awaddr_q == `SSIHR_OFF_SPIDBG)
        spi_dbg_q <= wmerged[23:0];
    end
  end

  // host control: link capture takes precedence over a software write in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      host_ctrl_q <= 8'h00;
    else if (cap_ctrl)
      host_ctrl_q <= rx_byte;
    else if (wr_go && awaddr_q == `SSIHR_OFF_HOST_CONTROL_IN)
      host_ctrl_q <= wmerged[7:0];
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      raw_q <= `SSIHR_RST_IRQ;
      irq <= 1'b0;
    end
    else
    begin
      raw_q <= raw_d;
      irq <= |(raw_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // fifos
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_wp_q <= 4'h0;
      rx_rp_q <= 4'h0;
      tx_wp_q <= 4'h0;
      tx_rp_q <= 4'h0;
    end
    else
    begin
      if (link_push || sw_rx_push)
      begin
        rx_mem[rx_wp_q[2:0]] <= link_push ? rx_byte : wdata_q[7:0];
        rx_wp_q <= rx_wp_q + 4'h1;
      end
      if (sw_rx_pop)
        rx_rp_q <= rx_rp_q + 4'h1;
      if (sw_tx_push)
      begin
        tx_mem[tx_wp_q[2:0]] <= wdata_q[7:0];
        tx_wp_q <= tx_wp_q + 4'h1;
      end
      if (link_pop || sw_tx_pop)
        tx_rp_q <= tx_rp_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // host link, mode 0, msb first
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sel_s3_q <= 1'b1;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
    end
    else
    begin
      sck_s1_q <= link_sck;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      sel_s1_q <= link_sel_n;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      mosi_s1_q <= link_mosi;
      mosi_s2_q <= mosi_s1_q;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bit_cnt_q <= 3'h0;
      first_q <= 1'b0;
      rx_shift_q <= 8'h00;
      tx_shift_q <= `SSIHR_IDLE_BYTE;
      link_miso <= 1'b1;
      link_miso_oe <= 1'b0;
    end
    else
    begin
      link_miso_oe <= !sel_s2_q;
      if (sel_fall)
      begin
        bit_cnt_q <= 3'h0;
        first_q <= 1'b1;
        link_miso <= tx_next[7];
      end
      else if (sck_rise)
      begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        rx_shift_q <= rx_byte;
        if (byte_done)
          first_q <= 1'b0;
      end
      else if (sck_fall)
        link_miso <= tx_shift_q[3'h7 - bit_cnt_q];
      if (load_next)
        tx_shift_q <= tx_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_mask_write: assert property (wr_on && awaddr_q == `SSIHR_OFF_MASK |=> mask_q == $past(wdata_q[3:0]))
    else $error("mask write not stored");
  a_mask_bits_read: assert property (rd_go && araddr_q == `SSIHR_OFF_MASK |=> s_axi_rvalid && s_axi_rdata == {28'h0, $past(mask_q)})
    else $error("mask read wrong");
  a_raw_sticky: assert property (raw_q[`SSIHR_BIT_BREAK] && !clr[`SSIHR_BIT_BREAK] |=> raw_q[`SSIHR_BIT_BREAK])
    else $error("raw bit lost without clear");
  a_masked_view: assert property (rd_go && araddr_q == `SSIHR_OFF_MASKED |=> s_axi_rdata[3:0] == $past(raw_q & mask_q))
    else $error("masked read wrong");
  a_clear_upper: assert property (clr[3:1] != 3'h0 && events[3:1] == 3'h0 |=> (raw_q[3:1] & $past(clr[3:1])) == 3'h0)
    else $error("clear did not clear");
  a_clear_receive: assert property (clr[0] && !events[0] |=> !raw_q[0])
    else $error("receive clear failed");
  a_irq_level: assert property (##1 irq == |($past(raw_q) & $past(mask_q)))
    else $error("irq level mismatch");
  a_dma_zero: assert property (rd_go && araddr_q == `SSIHR_OFF_DMA |=> s_axi_rdata == 32'h0)
    else $error("dma register not zero");
  a_test_push: assert property (sw_rx_push && !sw_rx_pop |=> rx_cnt == $past(rx_cnt) + 4'h1)
    else $error("test write did not push");
  a_status_sent: assert property (send_stat |=> tx_shift_q == $past(stat_byte) && link_miso == $past(stat_byte[7]))
    else $error("status byte not loaded");
  a_ctrl_capture: assert property (cap_ctrl |=> host_ctrl_q == $past(rx_byte) && rx_wp_q == $past(rx_wp_q))
    else $error("control byte not captured");
  a_debug_reset: assert property ($rose(aresetn) |-> i2c_dbg_q == `SSIHR_RST_I2CDBG && spi_dbg_q == `SSIHR_RST_SPIDBG)
    else $error("debug reset values wrong");

  c_irq_raised: cover property (!irq ##1 irq);
  c_ctrl_byte: cover property (cap_ctrl);
  c_overrun: cover property (events[`SSIHR_BIT_OVERRUN]);
  c_write_read: cover property (wr_go ##[1:20] rd_go);

endmodule

// ---- ssihr_host_model.sv ----
// behavioural serial host on the link pins: spi mode 0, msb first
// assumes the bench calls open_frame, shift and close_frame in that order
`timescale 1ns/10ps
module ssihr_host_model (
  output logic link_sck,
  output logic link_sel_n,
  output logic link_mosi,
  input wire logic link_miso
);
  initial
  begin
    link_sck = 1'b0;
    link_sel_n = 1'b1;
    link_mosi = 1'b0;
  end

  // ----------------------------------------
  // frame tasks, sck stands low between frames
  // ----------------------------------------
  task automatic open_frame();
    #30;
    link_sel_n = 1'b0;
    #800;
  endtask

  // nbits below 8 leaves a partial byte, which the slave reports as a break
  task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      link_mosi = tx[i];
      #400;
      link_sck = 1'b1;
      rx[i] = link_miso;
      #400;
      link_sck = 1'b0;
    end
  endtask

  // released data line shows the inverse so a stale sample is not mistaken for data
  task automatic close_frame();
    #400;
    link_sel_n = 1'b1;
    link_mosi = ~link_mosi;
    #800;
  endtask
endmodule

// ---- serial_slave_irq_host_regs_tb.sv ----
// self-checking bench for the serial slave irq/host register group
// assumes the host model on the link pins; the axi4-lite master lives here
`timescale 1ns/10ps
`include "ssihr_regs.svh"
module serial_slave_irq_host_regs_tb
  import ssihr_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic link_sck, link_sel_n, link_mosi, link_miso, link_miso_oe, irq;
  logic [31:0] d;
  ssihr_byte_type hb;
  int error_cnt = 0;
  int n_tests = 0;

  always #50 aclk = ~aclk;

  ssihr_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .link_sck, .link_sel_n, .link_mosi, .link_miso, .link_miso_oe, .irq);
  ssihr_host_model i_host (.link_sck, .link_sel_n, .link_mosi, .link_miso);

  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic results();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tmo();
    error_cnt++;
    $display("ERROR at %0t got %h exp %h, no bus answer", $time, 1'b0, 1'b1);
    results();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && k < 40);
    if (k >= 40) tmo();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && k < 40);
    if (k >= 40) tmo();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // reserved bits are masked off, their read value carries no meaning
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(d & m, e);
  endtask

  task automatic frame(input logic [7:0] tx, input int n);
    i_host.open_frame();
    i_host.shift(tx, n, hb);
    i_host.close_frame();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rc(`SSIHR_OFF_MASK, 32'hF, 32'h0);
    rc(`SSIHR_OFF_RAW, 32'hF, 32'h0);
    rc(`SSIHR_OFF_MASKED, 32'hF, 32'h0);
    rc(`SSIHR_OFF_HSTAT, 32'hF, 32'h0);
    rc(`SSIHR_OFF_HOST_CONTROL_IN, 32'hFF, 32'h0);
    rc(`SSIHR_OFF_I2CDBG, 32'h03FFFFFF, 32'hE);
    rc(`SSIHR_OFF_SPIDBG, 32'h00FFFFFF, 32'h00400000);
    chk({31'h0, irq}, 32'h0);
    $display("reset values done");
  endtask

  task automatic t_regs();
    wr(`SSIHR_OFF_MASK, 32'hF);
    rc(`SSIHR_OFF_MASK, 32'hF, 32'hF);
    wr(`SSIHR_OFF_MASK, 32'h5);
    rc(`SSIHR_OFF_MASK, 32'hF, 32'h5);
    wr(`SSIHR_OFF_MASK, 32'h0);
    rc(`SSIHR_OFF_MASK, 32'hF, 32'h0);
    // a write with its low byte lane off must leave the mask alone
    s_axi_wstrb <= 4'h0;
    wr(`SSIHR_OFF_MASK, 32'hF);
    s_axi_wstrb <= 4'hF;
    rc(`SSIHR_OFF_MASK, 32'hF, 32'h0);
    wr(`SSIHR_OFF_I2CDBG, 32'h03FFFFF1);
    rc(`SSIHR_OFF_I2CDBG, 32'h03FFFFFF, 32'h03FFFFF1);
    wr(`SSIHR_OFF_SPIDBG, 32'h00ABCDEF);
    rc(`SSIHR_OFF_SPIDBG, 32'h00FFFFFF, 32'h00ABCDEF);
    wr(`SSIHR_OFF_HSTAT, 32'hA);
    rc(`SSIHR_OFF_HSTAT, 32'hF, 32'hA);
    wr(`SSIHR_OFF_DMA, 32'h0);
    chk({30'h0, r}, {30'h0, `SSIHR_RESP_OKAY});
    // the data of this read carries no meaning, only the response is judged
    rd(`SSIHR_OFF_DMA);
    chk({30'h0, r}, {30'h0, `SSIHR_RESP_OKAY});
    wr(8'h30, 32'h0);
    chk({30'h0, r}, {30'h0, `SSIHR_RESP_SLVERR});
    rd(8'h30);
    chk({30'h0, r}, {30'h0, `SSIHR_RESP_SLVERR});
    $display("register access done");
  endtask

  task automatic t_irq();
    wr(`SSIHR_OFF_CLEAR, 32'hF);
    wr(`SSIHR_OFF_DATA, 32'h96);
    frame(8'h3C, 8);
    chk({24'h0, hb}, 32'h96);
    rc(`SSIHR_OFF_RAW, 32'hF, 32'h3);
    rc(`SSIHR_OFF_MASKED, 32'hF, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`SSIHR_OFF_MASK, 32'h1);
    rc(`SSIHR_OFF_MASKED, 32'hF, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(`SSIHR_OFF_CLEAR, 32'h1);
    rc(`SSIHR_OFF_RAW, 32'hF, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(`SSIHR_OFF_MASK, 32'h2);
    rc(`SSIHR_OFF_MASKED, 32'hF, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(`SSIHR_OFF_CLEAR, 32'h2);
    rc(`SSIHR_OFF_RAW, 32'hF, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rc(`SSIHR_OFF_DATA, 32'hFF, 32'h3C);
    $display("interrupt path done");
  endtask

  task automatic t_fifo();
    wr(`SSIHR_OFF_CLEAR, 32'hF);
    for (int i = 0; i < 8; i++)
      wr(`SSIHR_OFF_TEST, 32'h10 + 32'(i));
    frame(8'h77, 8);
    rc(`SSIHR_OFF_RAW, 32'hD, 32'h8);
    frame(8'h01, 3);
    rc(`SSIHR_OFF_RAW, 32'hD, 32'hC);
    wr(`SSIHR_OFF_CLEAR, 32'hC);
    rc(`SSIHR_OFF_RAW, 32'hD, 32'h0);
    for (int i = 0; i < 8; i++)
      rc(`SSIHR_OFF_DATA, 32'hFF, 32'h10 + 32'(i));
    wr(`SSIHR_OFF_DATA, 32'h5A);
    rc(`SSIHR_OFF_TEST, 32'hFF, 32'h5A);
    $display("fifo test port done");
  endtask

  // status byte is {host status, tx full, tx empty, rx full, rx empty}; both fifos are empty here
  task automatic t_host();
    wr(`SSIHR_OFF_CLEAR, 32'hF);
    wr(`SSIHR_OFF_CONFIG, 32'h60);
    wr(`SSIHR_OFF_HSTAT, 32'h9);
    i_host.open_frame();
    chk({31'h0, link_miso_oe}, 32'h1);
    i_host.shift(8'hC3, 8, hb);
    i_host.close_frame();
    chk({24'h0, hb}, 32'h95);
    chk({31'h0, link_miso_oe}, 32'h0);
    rc(`SSIHR_OFF_HOST_CONTROL_IN, 32'hFF, 32'hC3);
    rc(`SSIHR_OFF_RAW, 32'h1, 32'h0);
    rc(`SSIHR_OFF_DATA, 32'hFF, 32'h0);
    $display("host exchange done");
  endtask

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_regs();
    t_irq();
    t_fifo();
    t_host();
    results();
  end
endmodule
